// *** rtl/stg_pkg.sv ***
package stg_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [13:0] IDX_SOUND_CONTROL = 14'h005e;
    localparam logic [13:0] IDX_PITCH_RELOAD = 14'h1946;
    localparam logic [13:0] IDX_AMPLITUDE_LEVEL = 14'h1947;
    localparam logic [13:0] IDX_FADE_GRADE = 14'h1948;
    localparam logic [13:0] IDX_TONE_INTERRUPT_COUNT = 14'h1949;

    // Field positions inside the sound control word.
    localparam int CTL_RUN_BIT = 0;
    localparam int CTL_IRQ_FLAG = 1;
    localparam int CTL_IRQ_ENABLE = 2;
    localparam int CTL_AMP_PIN_EN = 3;
    localparam int CTL_SOUND_PIN_EN = 4;
    localparam int CTL_SQUARE_ONLY = 5;
    localparam int CTL_CLK_SEL_LO = 6;
    localparam int CTL_FADE_EN = 8;
    localparam int CTL_BUSY = 9;
    localparam int CTL_RESERVED = 15;

    // Values after reset.
    localparam logic [7:0] RST_AMPLITUDE = 8'h00;
    localparam logic [7:0] RST_PITCH = 8'h00;
    localparam logic [7:0] RST_GRADE = 8'h00;
    localparam logic [7:0] RST_TONE_COUNT = 8'h00;

    // Amplitude value that holds the pulse output permanently high.
    localparam logic [7:0] AMP_FULL = 8'hff;

    // Clock select codes.
    localparam logic [1:0] CLK_DIV1 = 2'h0;
    localparam logic [1:0] CLK_DIV2 = 2'h1;
    localparam logic [1:0] CLK_DIV4 = 2'h2;
    localparam logic [1:0] CLK_DIV8 = 2'h3;

    // Control bits that software writes.
    typedef struct packed {
        logic reserved_b;
        logic fade_en;
        logic [1:0] clk_sel;
        logic square_only;
        logic sound_pin_en;
        logic amp_pin_en;
        logic irq_en;
        logic irq_flag;
        logic run_bit;
    } stg_ctrl_t;

    localparam stg_ctrl_t CTRL_RESET = '0;

    // Generator sequencing, one-hot.
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_RUN = 3'b010,
        SEQ_DRAIN = 3'b100
    } stg_state_t;

    // Pin group: level plus output enable.
    typedef struct packed {
        logic level;
        logic oe;
    } stg_pin_t;

endpackage : stg_pkg

// *** rtl/stg_top.sv ***
// What this block does
// - Busy rises with run, falls after run clears and tone cycle ends.
// - With fade enabled, amplitude drops by one per decrement carry.
// - Clock select picks machine clock divided by one, two, four or eight.
// - Square-only gives plain tone; otherwise tone AND pulse width output.
// - Sound pin enable routes the sound output; else pin left to port.
// - Amplitude pin enable routes raw pulses to their pin.
// - Interrupt request is high while enable and flag are both one.
// - Flag sets when the tone pulse counter runs out.
// - Writing zero clears the flag; locked reads return one for it.
// - Runs while run is set; after clearing, finishes current tone cycle.
// - Rising run bit loads all four counters from their registers.
// - Pitch counter reloads on its own underflow; steps at pulse period end.
// - Tone is a half-duty square; changing pitch while running may skew it.
// - Pulse width generator takes the amplitude at each tone falling edge.
// - Fading stops at zero amplitude; generator keeps running.
// - Amplitude of all ones holds the pulse output high.
// - Decrement counter reloads on underflow; steps at tone falling edge.
// - Decrement counter spans grade plus one tone cycles.
// - Tone pulse counter reloads on underflow; steps on decrement carry.
// - Interrupt every (grade+1)*(count+1) tone cycles.
module stg_top (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hmastlock,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Sound pins and interrupt.
    output logic sound_out_o,
    output logic sound_out_oe,
    output logic amplitude_out_o,
    output logic amplitude_out_oe,
    output logic irq
);

    // One counter step: returns underflow in the top bit, next value below.
    function automatic logic [8:0] count_step(input logic [7:0] cnt,
                                              input logic [7:0] reload);
        if (cnt == 8'h00)
        begin
            count_step = {1'b1, reload};
        end
        else
        begin
            count_step = {1'b0, cnt - 8'h01};
        end
    endfunction : count_step

    stg_pkg::stg_ctrl_t ctrl_q;
    stg_pkg::stg_state_t state_q;
    logic [7:0] amplitude_q;
    logic [7:0] pitch_q;
    logic [7:0] grade_q;
    logic [7:0] tone_count_q;
    logic [13:0] addr_idx_q;
    logic wr_pend_q;
    logic rd_wait_q;
    logic rd_lock_q;
    logic [31:0] hrdata_q;
    logic run_prev_q;
    logic [2:0] presc_q;
    logic [7:0] phase_q;
    logic [7:0] pitch_cnt_q;
    logic [7:0] amp_cnt_q;
    logic [7:0] fade_cnt_q;
    logic [7:0] tone_cnt_q;
    logic tone_q;
    logic sound_q;
    logic pulse_q;
    logic busy;
    logic start;
    logic tick;
    logic [2:0] presc_mask;
    logic period_end;
    logic pitch_under;
    logic tone_fall;
    logic fade_carry;
    logic tone_carry;
    logic pulse_d;
    logic [8:0] pitch_step;
    logic [8:0] fade_step;
    logic [8:0] tone_step;
    logic addr_ok;
    logic wr_ctrl;
    logic wr_amp;
    logic [15:0] ctrl_word;

    // Bus decode: a transfer is taken when selected, non-idle and ready.
    assign addr_ok = hsel && htrans[1] && hready;
    assign wr_ctrl = wr_pend_q && addr_idx_q == stg_pkg::IDX_SOUND_CONTROL;
    assign wr_amp = wr_pend_q && addr_idx_q == stg_pkg::IDX_AMPLITUDE_LEVEL;
    // Reads take one wait state so a read right after a write sees the write.
    assign hreadyout = ~rd_wait_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // Address phase capture; only whole-word single transfers are expected.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            addr_idx_q <= 14'h0000;
            wr_pend_q <= 1'b0;
            rd_wait_q <= 1'b0;
            rd_lock_q <= 1'b0;
        end
        else
        begin
            addr_idx_q <= addr_ok ? haddr[15:2] : addr_idx_q;
            wr_pend_q <= addr_ok && hwrite;
            rd_wait_q <= addr_ok && !hwrite;
            rd_lock_q <= addr_ok && !hwrite && hmastlock;
        end
    end

    // Readable view of the control word with live busy state.
    always_comb
    begin
        ctrl_word = 16'h0000;
        ctrl_word[stg_pkg::CTL_RESERVED] = ctrl_q.reserved_b;
        ctrl_word[stg_pkg::CTL_BUSY] = busy;
        ctrl_word[stg_pkg::CTL_FADE_EN] = ctrl_q.fade_en;
        ctrl_word[stg_pkg::CTL_CLK_SEL_LO +: 2] = ctrl_q.clk_sel;
        ctrl_word[stg_pkg::CTL_SQUARE_ONLY] = ctrl_q.square_only;
        ctrl_word[stg_pkg::CTL_SOUND_PIN_EN] = ctrl_q.sound_pin_en;
        ctrl_word[stg_pkg::CTL_AMP_PIN_EN] = ctrl_q.amp_pin_en;
        ctrl_word[stg_pkg::CTL_IRQ_ENABLE] = ctrl_q.irq_en;
        // A locked read stands for read-modify-write, so the flag
        // reads one and the write-back cannot clear a pending event.
        ctrl_word[stg_pkg::CTL_IRQ_FLAG] = ctrl_q.irq_flag | rd_lock_q;
        ctrl_word[stg_pkg::CTL_RUN_BIT] = ctrl_q.run_bit;
    end

    // Read data is registered in the wait cycle; unmapped words read zero.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            hrdata_q <= 32'h0000_0000;
        end
        else if (rd_wait_q)
        begin
            case (addr_idx_q)
                stg_pkg::IDX_SOUND_CONTROL: hrdata_q <= {16'h0000, ctrl_word};
                stg_pkg::IDX_PITCH_RELOAD: hrdata_q <= {24'h000000, pitch_q};
                stg_pkg::IDX_AMPLITUDE_LEVEL:
                    hrdata_q <= {24'h000000, amplitude_q};
                stg_pkg::IDX_FADE_GRADE: hrdata_q <= {24'h000000, grade_q};
                stg_pkg::IDX_TONE_INTERRUPT_COUNT:
                    hrdata_q <= {24'h000000, tone_count_q};
                default: hrdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Control register; busy is not stored so writes to it have no effect.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ctrl_q <= stg_pkg::CTRL_RESET;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_q.reserved_b <= hwdata[stg_pkg::CTL_RESERVED];
                ctrl_q.fade_en <= hwdata[stg_pkg::CTL_FADE_EN];
                ctrl_q.clk_sel <= hwdata[stg_pkg::CTL_CLK_SEL_LO +: 2];
                ctrl_q.square_only <= hwdata[stg_pkg::CTL_SQUARE_ONLY];
                ctrl_q.sound_pin_en <= hwdata[stg_pkg::CTL_SOUND_PIN_EN];
                ctrl_q.amp_pin_en <= hwdata[stg_pkg::CTL_AMP_PIN_EN];
                ctrl_q.irq_en <= hwdata[stg_pkg::CTL_IRQ_ENABLE];
                ctrl_q.run_bit <= hwdata[stg_pkg::CTL_RUN_BIT];
            end
            // Hardware set beats a software clear in the same cycle.
            if (tone_carry)
            begin
                ctrl_q.irq_flag <= 1'b1;
            end
            else if (wr_ctrl && !hwdata[stg_pkg::CTL_IRQ_FLAG])
            begin
                ctrl_q.irq_flag <= 1'b0;
            end
        end
    end

    // Reload registers; a software write to amplitude wins over a fade step.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            amplitude_q <= stg_pkg::RST_AMPLITUDE;
            pitch_q <= stg_pkg::RST_PITCH;
            grade_q <= stg_pkg::RST_GRADE;
            tone_count_q <= stg_pkg::RST_TONE_COUNT;
        end
        else
        begin
            if (wr_pend_q && addr_idx_q == stg_pkg::IDX_PITCH_RELOAD)
            begin
                pitch_q <= hwdata[7:0];
            end
            if (wr_pend_q && addr_idx_q == stg_pkg::IDX_FADE_GRADE)
            begin
                grade_q <= hwdata[7:0];
            end
            if (wr_pend_q && addr_idx_q == stg_pkg::IDX_TONE_INTERRUPT_COUNT)
            begin
                tone_count_q <= hwdata[7:0];
            end
            if (wr_amp)
            begin
                amplitude_q <= hwdata[7:0];
            end
            else if (fade_carry && ctrl_q.fade_en && amplitude_q != 8'h00)
            begin
                amplitude_q <= amplitude_q - 8'h01;
            end
        end
    end

    // Run sequencing: drain to the end of the tone cycle before idling.
    assign start = ctrl_q.run_bit && !run_prev_q;
    assign busy = state_q != stg_pkg::SEQ_IDLE;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_q <= stg_pkg::SEQ_IDLE;
            run_prev_q <= 1'b0;
        end
        else
        begin
            run_prev_q <= ctrl_q.run_bit;
            case (state_q)
                stg_pkg::SEQ_IDLE:
                    if (start)
                    begin
                        state_q <= stg_pkg::SEQ_RUN;
                    end
                stg_pkg::SEQ_RUN:
                    if (!ctrl_q.run_bit)
                    begin
                        state_q <= stg_pkg::SEQ_DRAIN;
                    end
                stg_pkg::SEQ_DRAIN:
                    if (ctrl_q.run_bit)
                    begin
                        state_q <= stg_pkg::SEQ_RUN;
                    end
                    else if (tone_fall)
                    begin
                        state_q <= stg_pkg::SEQ_IDLE;
                    end
                default: state_q <= stg_pkg::SEQ_IDLE;
            endcase
        end
    end

    // Prescaler: the divider counts while busy and the select picks its tap mask.
    always_comb
    begin
        case (ctrl_q.clk_sel)
            stg_pkg::CLK_DIV1: presc_mask = 3'h0;
            stg_pkg::CLK_DIV2: presc_mask = 3'h1;
            stg_pkg::CLK_DIV4: presc_mask = 3'h3;
            stg_pkg::CLK_DIV8: presc_mask = 3'h7;
            default: presc_mask = 3'h0;
        endcase
    end
    assign tick = busy && (presc_q & presc_mask) == presc_mask;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || !busy)
        begin
            presc_q <= 3'h0;
        end
        else
        begin
            presc_q <= presc_q + 3'h1;
        end
    end

    // Counter steps and the events that chain them together.
    assign period_end = tick && phase_q == 8'hff;
    assign pitch_step = count_step(pitch_cnt_q, pitch_q);
    assign pitch_under = period_end && pitch_step[8];
    assign tone_fall = pitch_under && tone_q;
    assign fade_step = count_step(fade_cnt_q, grade_q);
    assign fade_carry = tone_fall && fade_step[8];
    assign tone_step = count_step(tone_cnt_q, tone_count_q);
    assign tone_carry = fade_carry && tone_step[8];

    // Pulse phase counter; its wrap is the period end that steps the pitch.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || start)
        begin
            phase_q <= 8'h00;
        end
        else if (tick)
        begin
            phase_q <= phase_q + 8'h01;
        end
    end

    // Pitch counter and tone toggle; a new pitch shows at the next reload,
    // so a mid-cycle change can leave one half period uneven.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            pitch_cnt_q <= stg_pkg::RST_PITCH;
            tone_q <= 1'b0;
        end
        else if (start)
        begin
            pitch_cnt_q <= pitch_q;
            tone_q <= 1'b0;
        end
        else if (period_end)
        begin
            pitch_cnt_q <= pitch_step[7:0];
            tone_q <= tone_q ^ pitch_step[8];
        end
    end

    // Amplitude working copy for the pulse generator.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            amp_cnt_q <= stg_pkg::RST_AMPLITUDE;
        end
        else if (start || tone_fall)
        begin
            amp_cnt_q <= amplitude_q;
        end
    end

    // Decrement counter advances once per tone cycle, tone pulse counter once per decrement carry.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            fade_cnt_q <= stg_pkg::RST_GRADE;
            tone_cnt_q <= stg_pkg::RST_TONE_COUNT;
        end
        else if (start)
        begin
            fade_cnt_q <= grade_q;
            tone_cnt_q <= tone_count_q;
        end
        else if (tone_fall)
        begin
            fade_cnt_q <= fade_step[7:0];
            if (fade_carry)
            begin
                tone_cnt_q <= tone_step[7:0];
            end
        end
    end

    // Pulse is high for amplitude phases of each period, all-ones stays high.
    assign pulse_d = busy && (amp_cnt_q == stg_pkg::AMP_FULL
                              || phase_q < amp_cnt_q);

    // Output flops so the pins carry no decode glitches.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            pulse_q <= 1'b0;
            sound_q <= 1'b0;
        end
        else
        begin
            pulse_q <= pulse_d;
            sound_q <= ctrl_q.square_only ? tone_q
                                          : (tone_q & pulse_d);
        end
    end

    // Pin routing; the port direction bit lives outside this block.
    assign sound_out_o = sound_q;
    assign sound_out_oe = ctrl_q.sound_pin_en;
    assign amplitude_out_o = pulse_q;
    assign amplitude_out_oe = ctrl_q.amp_pin_en;
    assign irq = ctrl_q.irq_en && ctrl_q.irq_flag;

endmodule : stg_top

// *** test/sound_tone_generator_test.sv ***
module sound_tone_generator_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LIMIT = 60000;
    localparam logic [13:0] I_CTL = stg_pkg::IDX_SOUND_CONTROL;
    localparam logic [13:0] I_PIT = stg_pkg::IDX_PITCH_RELOAD;
    localparam logic [13:0] I_AMP = stg_pkg::IDX_AMPLITUDE_LEVEL;
    localparam logic [13:0] I_GRD = stg_pkg::IDX_FADE_GRADE;
    localparam logic [13:0] I_CNT = stg_pkg::IDX_TONE_INTERRUPT_COUNT;
    logic clk_sys, sys_rst, hsel, hwrite, hmastlock;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, port_dir;
    logic [2:0] hsize;
    logic hreadyout, hresp, sound_out_o, sound_out_oe;
    logic amplitude_out_o, amplitude_out_oe, irq, snd, amp;
    logic [13:0] regs [6];
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;

    stg_top uut (.clk_sys, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hmastlock, .hwdata, .hready(hreadyout), .hreadyout,
        .hresp, .hrdata, .sound_out_o, .sound_out_oe, .amplitude_out_o,
        .amplitude_out_oe, .irq);
    stg_speaker spk (.sound_out_o, .sound_out_oe, .amplitude_out_o,
        .amplitude_out_oe, .port_dir, .sound_pin(snd), .amp_pin(amp));

    // Prints the counts and the verdict, then stops.
    task end_sim();
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    // Compares one value and counts the outcome.
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // One single AHB transfer; the answer is awaited, never assumed.
    task xfer(input logic [13:0] ix, input logic w, input logic lk,
        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {16'h0000, ix, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        hmastlock <= lk;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1)
            @(posedge clk_sys);
        htrans <= 2'h0;
        hmastlock <= 1'b0;
        hwdata <= d; // Callers keep the reserved top bit clear.
        @(posedge clk_sys);
        while (hreadyout !== 1'b1)
            @(posedge clk_sys);
        rd = hrdata;
    endtask : xfer

    task wr(input logic [13:0] ix, input logic [31:0] d);
        xfer(ix, 1'b1, 1'b0, d);
    endtask : wr

    task rdr(input logic [13:0] ix, input logic lk);
        xfer(ix, 1'b0, lk, 32'h0);
    endtask : rdr

    // Length of the next high stretch of the sound pin, in clocks.
    task half(output int n);
        n = 0;
        while (snd !== 1'b0)
            @(posedge clk_sys);
        while (snd !== 1'b1)
            @(posedge clk_sys);
        while (snd === 1'b1)
        begin
            n++;
            @(posedge clk_sys);
        end
    endtask : half

    // Waits for a number of falling edges on the sound pin.
    task falls(input int n);
        int k;
        logic p;
        k = 0;
        p = snd;
        while (k < n)
        begin
            @(posedge clk_sys);
            if (p && !snd)
                k++;
            p = snd;
        end
    endtask : falls

    // Clears run, keeping the other bits, and waits for the drain.
    task stop(input logic [31:0] c);
        int k;
        wr(I_CTL, c & ~32'h1);
        rdr(I_CTL, 1'b0);
        check(32'(rd[9]), 32'h1);
        k = 0;
        while (rd[9] === 1'b1 && k < 2000)
        begin
            rdr(I_CTL, 1'b0);
            k++;
        end
        check(32'(rd[9]), 32'h0);
        check(32'(sound_out_o), 32'h0);
    endtask : stop

    // Free-running system clock.
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Watchdog: a hang counts as a mismatch.
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            err_total++;
            end_sim();
        end
    end

    // Main sequence of tests.
    initial
    begin
        int n, k, m, e;
        logic p;
        logic [31:0] c;
        {hsel, hwrite, hmastlock, sys_rst} = 4'h1;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        port_dir = 2'h3;
        regs = '{I_CTL, I_PIT, I_AMP, I_GRD, I_CNT, 14'h0001};
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        foreach (regs[i])
        begin
            rdr(regs[i], 1'b0);
            check(rd, 32'h0);
        end
        for (int i = 1; i < 6; i++)
        begin
            wr(regs[i], 32'h5a + 32'(i));
            rdr(regs[i], 1'b0);
            check(rd, i < 5 ? 32'h5a + 32'(i) : 32'h0);
        end
        wr(I_CTL, 32'h200);
        rdr(I_CTL, 1'b0);
        check(rd, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 5; i++)
        begin
            c = 32'h31 | 32'(i % 4) << 6;
            e = (256 << (i % 4)) * (i / 4 + 1);
            wr(I_PIT, 32'(i / 4));
            wr(I_CTL, c);
            half(n);
            check(32'(n), 32'(e));
            stop(c);
        end
        $display("test clock select done");
        wr(I_PIT, 32'h0);
        for (int j = 0; j < 2; j++)
        begin
            wr(I_AMP, j ? 32'hff : 32'h80);
            wr(I_CTL, 32'h19);
            half(n);
            check(32'(n), j ? 32'h100 : 32'h80);
            k = 0;
            repeat (512)
            begin
                @(posedge clk_sys);
                if (amp === 1'b1)
                    k++;
            end
            check(32'(k), j ? 32'h200 : 32'h100);
            stop(32'h19);
        end
        $display("test pulse width done");
        wr(I_GRD, 32'h1);
        wr(I_CNT, 32'h1);
        wr(I_CTL, 32'h35);
        k = 0;
        m = 0;
        p = 1'b0;
        while (m < 3)
        begin
            @(posedge clk_sys);
            if (p && !snd)
                k++;
            p = snd;
            if (irq === 1'b1)
                m++;
        end
        check(32'(k), 32'h4);
        check(32'(amplitude_out_oe), 32'h0);
        wr(I_CTL, 32'h33);
        @(posedge clk_sys);
        check(32'(irq), 32'h0);
        rdr(I_CTL, 1'b0);
        check(32'(rd[1]), 32'h1);
        wr(I_CTL, 32'h37);
        @(posedge clk_sys);
        check(32'(irq), 32'h1);
        wr(I_CTL, 32'h35);
        @(posedge clk_sys);
        check(32'(irq), 32'h0);
        rdr(I_CTL, 1'b0);
        check(32'(rd[1]), 32'h0);
        rdr(I_CTL, 1'b1);
        check(32'(rd[1]), 32'h1);
        stop(32'h35);
        $display("test interrupt done");
        wr(I_AMP, 32'h3);
        wr(I_CTL, 32'h131);
        falls(1);
        rdr(I_AMP, 1'b0);
        check(rd, 32'h3);
        falls(1);
        rdr(I_AMP, 1'b0);
        check(rd, 32'h2);
        falls(6);
        rdr(I_AMP, 1'b0);
        check(rd, 32'h0);
        rdr(I_CTL, 1'b0);
        check(32'(rd[9]), 32'h1);
        stop(32'h131);
        $display("test fade done");
        end_sim();
    end
endmodule : sound_tone_generator_test

bind stg_top stg_chk chk (.clk_sys, .sys_rst, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .sound_out_oe,
    .amplitude_out_oe, .irq);

// *** test/stg_chk.sv ***
module stg_chk (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Bus side.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Pins.
    input wire logic sound_out_oe,
    input wire logic amplitude_out_oe,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    logic take, ctl_q, soe_q, aoe_q, ie_q;
    // A transfer accepted by the slave.
    assign take = hsel && htrans[1] && hready;
    // Shadow of the control enables, rebuilt from bus writes alone.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ctl_q <= 1'b0;
            {soe_q, aoe_q, ie_q} <= 3'h0;
        end
        else if (hready)
        begin
            ctl_q <= take && hwrite
                && haddr[15:2] == stg_pkg::IDX_SOUND_CONTROL;
            if (ctl_q)
                {soe_q, aoe_q, ie_q} <= hwdata[4:2];
        end
    end
    // A read stalls for exactly one cycle.
    sequence s_rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    AST_RD_WAIT: assert property (take && !hwrite |=> s_rd_wait)
        else $error("read wait cycle wrong");
    AST_WR_ZERO: assert property (take && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    AST_OKAY: assert property (hresp == 1'b0)
        else $error("response not okay");
    AST_RD_HOLD: assert property (hreadyout && $past(hreadyout)
        |-> $stable(hrdata))
        else $error("read data moved while idle");
    AST_SND_OE: assert property (sound_out_oe == soe_q)
        else $error("sound pin enable differs from control");
    AST_AMP_OE: assert property (amplitude_out_oe == aoe_q)
        else $error("amplitude pin enable differs from control");
    AST_IRQ_EN: assert property (irq |-> ie_q)
        else $error("interrupt raised while disabled");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(ctl_q))
        else $error("interrupt dropped without a control write");
    AST_RST_OUT: assert property ($fell(sys_rst)
        |-> hreadyout && !irq && !sound_out_oe)
        else $error("outputs not idle after reset");
endmodule : stg_chk

// *** test/stg_speaker.sv ***
module stg_speaker (
    // Design pins.
    input wire logic sound_out_o,
    input wire logic sound_out_oe,
    input wire logic amplitude_out_o,
    input wire logic amplitude_out_oe,
    // Port direction bits that software sets.
    input wire logic [1:0] port_dir,
    // Levels the speaker sees.
    output logic sound_pin,
    output logic amp_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // Undriven pins fall to the pull-down, so a lost enable reads as silence.
    assign sound_pin = sound_out_oe && port_dir[0]
        ? sound_out_o : 1'b0;
    assign amp_pin = amplitude_out_oe && port_dir[1]
        ? amplitude_out_o : 1'b0;
endmodule : stg_speaker
